// ### pkg/spd_pkg.sv
package spd_pkg;

  // Register space bounds
  localparam logic [7:0] SPD_SFR_BASE = 8'h80;
  localparam logic [7:0] SPD_SFR_LAST = 8'hff;
  localparam logic [7:0] SPD_LOWER_TOP = 8'h7f;

  // Page select register
  localparam logic [7:0] SPD_PAGE_ADDR = 8'h91;
  localparam logic [7:0] SPD_PAGE_RST = 8'h00;
  localparam int SPD_PAGE_BIT = 0;

  // Timed access key register and unlock values
  localparam logic [7:0] SPD_KEY_ADDR = 8'hc7;
  localparam logic [7:0] SPD_KEY_FIRST = 8'haa;
  localparam logic [7:0] SPD_KEY_SECOND = 8'h55;

  // Unlock window length in cycles after the second key byte
  localparam int SPD_UNLOCK_CYCLES = 4;

  // Bit addressing: bit address 8'h80..8'hff maps to byte {addr[7:3],3'b0}
  localparam logic [2:0] SPD_BIT_LOW_MASK = 3'h0;

  // Access kinds of the core
  typedef enum logic [1:0]
  {
    SPD_ACC_DIRECT,
    SPD_ACC_INDIRECT,
    SPD_ACC_BIT
  } spd_acc_kind_t;

  // One core request
  typedef struct packed
  {
    logic valid;
    logic write;
    spd_acc_kind_t kind;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spd_req_t;

  // Decoded target
  typedef struct packed
  {
    logic sfr_sel;
    logic ram_sel;
    logic page1;
    logic bit_op;
    logic [7:0] addr;
    logic [2:0] bit_idx;
  } spd_sel_t;

endpackage : spd_pkg

// ### design/spd_page_alt.sv
`timescale 1ns/1ps
// Tells whether a byte address has a distinct page-1 register
module spd_page_alt
  import spd_pkg::*;
(
  // Address in
  input wire logic [7:0] addr,
  // Result
  output logic has_alt
);

  // Page-1 alternates from the register map
  always_comb
  begin
    case (addr)
      8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb7,
      8'hac, 8'had, 8'hcc, 8'hcd, 8'hc4, 8'hc5,
      8'hc6, 8'hf3:
        has_alt = 1'b1;
      default:
        has_alt = 1'b0;
    endcase
  end

endmodule : spd_page_alt

// ### design/spd_key_unlock.sv
`timescale 1ns/1ps
// Timed-access key sequencer
module spd_key_unlock
  import spd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Key writes and protected write consumption
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic prot_wr,
  // Unlock state
  output logic open_q
);

  typedef enum {SPD_K_IDLE, SPD_K_FIRST, SPD_K_OPEN} spd_kst_t;

  spd_kst_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic open_d;

  // Open window is short so a stray write later cannot hit the register
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      SPD_K_IDLE:
      begin
        if (key_wr && key_data == SPD_KEY_FIRST)
          st_d = SPD_K_FIRST;
      end
      SPD_K_FIRST:
      begin
        if (key_wr && key_data == SPD_KEY_SECOND)
        begin
          st_d = SPD_K_OPEN; // see [R11]
          cnt_d = 3'(SPD_UNLOCK_CYCLES - 1);
        end
        else if (key_wr && key_data == SPD_KEY_FIRST)
          st_d = SPD_K_FIRST;
        else if (key_wr || prot_wr)
          st_d = SPD_K_IDLE;
      end
      SPD_K_OPEN:
      begin
        // One protected write consumes the unlock
        if (prot_wr || cnt_q == 3'h0)
          st_d = SPD_K_IDLE; // see [R13]
        else
          cnt_d = cnt_q - 3'h1;
      end
      default:
        st_d = SPD_K_IDLE;
    endcase
    if (sys_rst)
    begin
      st_d = SPD_K_IDLE;
      cnt_d = 3'h0;
    end
    // Taken from the next state so the flag lines up with st_q
    open_d = (st_d == SPD_K_OPEN);
  end

  always_ff @(posedge clk)
  begin
    st_q <= st_d;
    cnt_q <= cnt_d;
    open_q <= open_d;
  end

endmodule : spd_key_unlock

// ### design/spd_sfr_decoder.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] Registers occupy data addresses 80 to FFH, one byte each.
// [R2] Only direct accesses select registers; indirect ones never do. The code also selects registers on bit accesses.
// [R3] Above 7FH direct goes to registers, indirect to upper RAM.
// [R4] Addresses ending 0H or 8H allow single-bit read and write.
// [R5] Other addresses take whole bytes only, ignoring bit access.
// [R6] Paging lets chosen addresses reach a different page-1 register.
// [R7] After reset every access goes to page 0.
// [R8] Addresses without an alternate decode the same on both pages.
// [R9] Bit 0 of page select chooses page; bits 7..1 unused.
// [R10] Page select sits at 91H and resets to zero.
// [R11] Writes to page select need AAH then 55H to the key first.
// [R12] Page select is guarded by the timed-access protection.
// [R13] Protected write without the unlock sequence is ignored.
// [R14] Software avoids reserved addresses; results there are undefined.
module spd_sfr_decoder
  import spd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Core request
  input wire spd_req_t req,
  // Read data of the peripheral register selected last cycle
  input wire logic [7:0] periph_rdata,
  // Decoded target to peripherals and upper RAM
  output spd_sel_t sel_q,
  output logic sel_write_q,
  output logic [7:0] sel_wdata_q,
  // Data returned to the core
  output logic [7:0] rdata_q,
  output logic rbit_q,
  // Page state
  output logic page_q
);

  logic [7:0] pgreg_q, pgreg_d;
  logic has_alt;
  logic key_open;
  logic key_wr;
  logic prot_wr;
  logic bit_ok;
  logic [7:0] byte_addr;
  logic direct_hit;
  logic own_hit;
  logic [7:0] own_data;
  logic own_rd_q, own_rd_d;
  logic [7:0] own_data_q;
  logic bit_rd_q, bit_rd_d;
  logic [2:0] bit_idx_q, bit_idx_d;
  spd_sel_t sel_d;
  logic [7:0] wdata_d;
  logic sel_write_d;
  logic [7:0] rdata_d;
  logic rbit_d;
  logic page_d;

  // Bit addressable when the low nibble is 0H or 8H
  function automatic logic bit_capable(input logic [7:0] a);
    return a[2:0] == SPD_BIT_LOW_MASK; // see [R4] [R5]
  endfunction : bit_capable

  // Byte address of a bit operand at or above 80H
  function automatic logic [7:0] bit_byte(input logic [7:0] a);
    return {a[7:3], 3'h0};
  endfunction : bit_byte

  spd_page_alt u_alt
  (
    .addr(byte_addr),
    .has_alt(has_alt)
  );

  spd_key_unlock u_key
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .key_wr(key_wr),
    .key_data(req.wdata),
    .prot_wr(prot_wr),
    .open_q(key_open)
  );

  // Address classification
  always_comb
  begin
    byte_addr = (req.kind == SPD_ACC_BIT) ? bit_byte(req.addr) : req.addr;
    bit_ok = bit_capable(byte_addr);
    // Indirect never lands in register space
    direct_hit = req.valid && req.addr > SPD_LOWER_TOP
      && req.kind != SPD_ACC_INDIRECT; // see [R1] [R2]
    own_hit = direct_hit && byte_addr == SPD_PAGE_ADDR
      && req.kind == SPD_ACC_DIRECT;
    key_wr = direct_hit && req.write && req.kind == SPD_ACC_DIRECT
      && byte_addr == SPD_KEY_ADDR;
    prot_wr = own_hit && req.write; // see [R12]
  end

  // Page select register, written only inside the unlock window
  always_comb
  begin
    pgreg_d = pgreg_q;
    if (prot_wr && key_open) // see [R11] [R13]
      pgreg_d = {7'h00, req.wdata[SPD_PAGE_BIT]}; // see [R9]
    if (sys_rst)
      pgreg_d = SPD_PAGE_RST; // see [R7] [R10]
    // Next page bit, so banked blocks switch at the write edge
    page_d = pgreg_d[SPD_PAGE_BIT];
  end

  always_ff @(posedge clk)
  begin
    pgreg_q <= pgreg_d;
  end

  // Target decode, registered for the peripherals
  always_comb
  begin
    sel_d = '0;
    wdata_d = req.wdata;
    sel_write_d = req.write;
    own_data = pgreg_q;
    sel_d.addr = byte_addr;
    sel_d.bit_idx = req.addr[2:0];
    if (req.valid && req.addr > SPD_LOWER_TOP
        && req.kind == SPD_ACC_INDIRECT)
      sel_d.ram_sel = 1'b1; // see [R3]
    else if (direct_hit && !own_hit)
    begin
      // Bit access on a byte-only address is dropped
      if (req.kind != SPD_ACC_BIT || bit_ok) // see [R5]
      begin
        sel_d.sfr_sel = 1'b1; // see [R3]
        sel_d.bit_op = (req.kind == SPD_ACC_BIT); // see [R4]
        // Page only matters where an alternate exists
        sel_d.page1 = has_alt & pgreg_q[SPD_PAGE_BIT]; // see [R6] [R8]
      end
    end
    own_rd_d = own_hit && !req.write;
    bit_rd_d = sel_d.bit_op && !req.write;
    bit_idx_d = req.addr[2:0];
    if (sys_rst)
    begin
      sel_d = '0;
      wdata_d = 8'h00;
      sel_write_d = 1'b0;
      own_data = 8'h00;
      own_rd_d = 1'b0;
      bit_rd_d = 1'b0;
      bit_idx_d = 3'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    sel_q <= sel_d;
    sel_write_q <= sel_write_d;
    sel_wdata_q <= wdata_d;
    own_rd_q <= own_rd_d;
    own_data_q <= own_data;
    bit_rd_q <= bit_rd_d;
    bit_idx_q <= bit_idx_d;
  end

  // Read return one cycle after the target select
  always_comb
  begin
    rdata_d = own_rd_q ? own_data_q : periph_rdata;
    rbit_d = bit_rd_q ? periph_rdata[bit_idx_q] : 1'b0; // see [R4]
    if (sys_rst)
    begin
      rdata_d = 8'h00;
      rbit_d = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    rdata_q <= rdata_d;
    rbit_q <= rbit_d;
  end

  // Page state for any block that banks by page
  always_ff @(posedge clk)
  begin
    page_q <= page_d;
  end

endmodule : spd_sfr_decoder

// ### verification/spd_periph_model.sv
`timescale 1ns/1ps
// Peripheral side: answers with a byte derived from the target
module spd_periph_model
  import spd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Decoded target
  input wire spd_sel_t sel_q,
  // Read data back
  output logic [7:0] periph_rdata
);
  // Known start, otherwise the inverse stays unknown forever
  logic [7:0] last_q = 8'h00;
  // Unselected: inverse of last value, so stale data never matches
  assign periph_rdata = (sel_q.sfr_sel || sel_q.ram_sel) ?
    sel_q.addr ^ {sel_q.page1, 7'h0} : ~last_q;
  // Last shown value
  always_ff @(posedge clk) last_q <= periph_rdata;
endmodule : spd_periph_model

// ### verification/spd_sfr_properties.sv
`timescale 1ns/1ps
// Port-level checks of the decoder
module spd_sfr_properties
  import spd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Inputs
  input wire spd_req_t req,
  input wire logic [7:0] periph_rdata,
  // Outputs
  input wire spd_sel_t sel_q,
  input wire logic sel_write_q,
  input wire logic [7:0] sel_wdata_q,
  input wire logic [7:0] rdata_q,
  input wire logic rbit_q,
  input wire logic page_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic dr;
  // Direct request present
  assign dr = req.valid && req.kind == SPD_ACC_DIRECT;
  sequence key_s(logic [7:0] v);
    dr && req.write && req.addr == SPD_KEY_ADDR && req.wdata == v;
  endsequence
  sequence pgw_s;
    dr && req.write && req.addr == SPD_PAGE_ADDR;
  endsequence
  reset_page_a: assert property (disable iff (1'b0) sys_rst |=>
    !page_q && !sel_q.sfr_sel) else $error("reset state wrong");
  unlock_page_a: assert property (key_s(SPD_KEY_FIRST) ##1
    key_s(SPD_KEY_SECOND) ##1 pgw_s |=> page_q == $past(req.wdata[0]))
    else $error("unlocked page write lost");
  direct_sfr_a: assert property (dr && req.addr[7] &&
    req.addr != SPD_PAGE_ADDR && req.addr != SPD_KEY_ADDR |=>
    sel_q.sfr_sel && sel_q.addr == $past(req.addr))
    else $error("direct select wrong");
  indirect_ram_a: assert property (req.valid &&
    req.kind == SPD_ACC_INDIRECT |=> !sel_q.sfr_sel &&
    sel_q.ram_sel == $past(req.addr[7])) else $error("indirect wrong");
  bit_map_a: assert property (req.valid &&
    req.kind == SPD_ACC_BIT && req.addr[7] |=> sel_q.bit_op &&
    sel_q.bit_idx == $past(req.addr[2:0]) &&
    sel_q.addr == {$past(req.addr[7:3]), 3'h0}) else $error("bit map");
  byte_only_a: assert property (dr |=> !sel_q.bit_op)
    else $error("byte access marked bit");
  page_read_a: assert property (dr && !req.write &&
    req.addr == SPD_PAGE_ADDR |=> !sel_q.sfr_sel ##1 rdata_q[7:1] == 7'h0)
    else $error("page read wrong");
  // Read byte stands one edge after the peripheral answered
  periph_read_a: assert property (dr && !req.write &&
    req.addr[7] && req.addr != SPD_PAGE_ADDR |->
    ##2 rdata_q == $past(periph_rdata))
    else $error("read data wrong");
  wr_pass_a: assert property (req.valid && req.write |=>
    sel_write_q && sel_wdata_q == $past(req.wdata))
    else $error("write data not passed");
  page_hold_a: assert property (!(dr && req.write &&
    req.addr == SPD_PAGE_ADDR) |=> page_q == $past(page_q))
    else $error("page moved without a page write");
endmodule : spd_sfr_properties
bind spd_sfr_decoder spd_sfr_properties spd_sfr_properties_i(.clk, .sys_rst,
  .req, .periph_rdata, .sel_q, .sel_write_q, .sel_wdata_q, .rdata_q, .rbit_q,
  .page_q);

// ### verification/spd_sfr_decoder_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t %h %h", $time, a, e); end end
module spd_sfr_decoder_test
  import spd_pkg::*;
;
  logic clk = 0, sys_rst = 1, pg = 0, rbit_q, page_q, sel_write_q;
  spd_req_t req = '0;
  spd_sel_t sel_q;
  logic [7:0] periph_rdata, sel_wdata_q, rdata_q, a;
  logic [8:0] e, exp_q[$];
  logic sh = 1'b0;
  int miscompares = 0, n_checks = 0, seed = 32;
  logic [7:0] alts[14] = '{8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb7, 8'hac,
    8'had, 8'hc4, 8'hc5, 8'hc6, 8'hcc, 8'hcd, 8'hf3};
  spd_sfr_decoder spd_sfr_decoder_i(.clk, .sys_rst, .req, .periph_rdata,
    .sel_q, .sel_write_q, .sel_wdata_q, .rdata_q, .rbit_q, .page_q);
  spd_periph_model spd_periph_model_i(.clk, .sel_q, .periph_rdata);
  // Clock
  initial forever #5 clk = ~clk;
  // One request per cycle; reads note what must come back
  task automatic acc(logic w, spd_acc_kind_t k, logic [7:0] ad,
    logic [7:0] d = 8'h00);
    logic [7:0] b;
    b = (k == SPD_ACC_BIT) ? {ad[7:3], 3'h0} : ad;
    b = (b == SPD_PAGE_ADDR) ? {7'h0, pg} : b ^ {pg && (b inside {alts}), 7'h0};
    req <= '{1'b1, w, k, ad, d};
    if (!w) exp_q.push_back((k == SPD_ACC_BIT) ? {1'b1, 7'h0, b[ad[2:0]]}
      : {1'b0, b});
    @(negedge clk);
  endtask : acc
  // Key bytes back to back
  task unlock;
    acc(1, SPD_ACC_DIRECT, SPD_KEY_ADDR, SPD_KEY_FIRST);
    acc(1, SPD_ACC_DIRECT, SPD_KEY_ADDR, SPD_KEY_SECOND);
  endtask : unlock
  task idle(int n);
    req <= '0;
    repeat (n) @(negedge clk);
  endtask : idle
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Result stands from the edge after the taking edge; seen at next fall
  always @(negedge clk)
  begin
    sh <= req.valid && !req.write;
    if (sh)
    begin
      e = exp_q.pop_front();
      if (e[8]) `CHK(rbit_q, e[0])
      else `CHK(rdata_q, e[7:0])
    end
  end
  // Main sequence
  initial
  begin
    repeat (3) @(negedge clk);
    sys_rst = 0;
    acc(0, SPD_ACC_DIRECT, SPD_PAGE_ADDR);
    acc(0, SPD_ACC_DIRECT, 8'hb1);
    acc(1, SPD_ACC_DIRECT, SPD_PAGE_ADDR, 8'h01);
    acc(0, SPD_ACC_DIRECT, SPD_PAGE_ADDR);
    // Aborted key sequence must keep the page locked
    acc(1, SPD_ACC_DIRECT, SPD_KEY_ADDR, SPD_KEY_FIRST);
    acc(1, SPD_ACC_DIRECT, SPD_KEY_ADDR, 8'h12);
    acc(1, SPD_ACC_DIRECT, SPD_KEY_ADDR, SPD_KEY_SECOND);
    acc(1, SPD_ACC_DIRECT, SPD_PAGE_ADDR, 8'h01);
    acc(0, SPD_ACC_DIRECT, SPD_PAGE_ADDR);
    unlock();
    acc(1, SPD_ACC_DIRECT, SPD_PAGE_ADDR, 8'hff);
    pg = 1;
    acc(0, SPD_ACC_DIRECT, SPD_PAGE_ADDR);
    foreach (alts[i]) acc(0, SPD_ACC_DIRECT, alts[i]);
    for (int i = 0; i < 40; i++)
    begin
      a = {1'b1, 7'($random(seed))};
      if (a inside {8'h84, 8'h85, 8'h91, 8'h9d, 8'h9e, 8'ha1, 8'hb6, 8'hc7,
        8'hfd, 8'hfe, 8'hff}) continue;
      acc(0, SPD_ACC_DIRECT, a);
      acc(0, SPD_ACC_BIT, a);
      acc(1, SPD_ACC_INDIRECT, a, a);
    end
    // Late page write falls outside the unlock window
    unlock();
    idle(6);
    acc(1, SPD_ACC_DIRECT, SPD_PAGE_ADDR, 8'h00);
    acc(0, SPD_ACC_DIRECT, SPD_PAGE_ADDR);
    unlock();
    acc(1, SPD_ACC_DIRECT, SPD_PAGE_ADDR, 8'h00);
    pg = 0;
    acc(0, SPD_ACC_DIRECT, 8'hb1);
    unlock();
    acc(1, SPD_ACC_DIRECT, SPD_PAGE_ADDR, 8'h01);
    idle(4);
    sys_rst = 1;
    @(negedge clk);
    sys_rst = 0;
    acc(0, SPD_ACC_DIRECT, SPD_PAGE_ADDR);
    idle(5);
    finish_test();
  end
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule : spd_sfr_decoder_test
